/* common/amc_pkg.sv */
package amc_pkg;
  // ==========================================================
  // Register byte addresses (multi-byte registers, LSB first)
  localparam logic [7:0] AMC_ADDR_EDGE_POS_B0 = 8'h2C;
  localparam logic [7:0] AMC_ADDR_EDGE_POS_B1 = 8'h2D;
  localparam logic [7:0] AMC_ADDR_EDGE_POS_B2 = 8'h2E;
  localparam logic [7:0] AMC_ADDR_FULL_SCALE_B0 = 8'h30;
  localparam logic [7:0] AMC_ADDR_FULL_SCALE_B1 = 8'h31;
  localparam logic [7:0] AMC_ADDR_POWER_MODE = 8'h37;
  localparam logic [7:0] AMC_ADDR_STAMP_CTRL = 8'h3B;

  // ==========================================================
  // Widths and reset values
  localparam int AMC_EDGE_POS_W = 24;
  localparam int AMC_FULL_SCALE_W = 16;
  localparam logic [23:0] AMC_EDGE_POS_RST = 24'h000000;
  localparam logic [15:0] AMC_FULL_SCALE_RST = 16'hA000;
  localparam logic [7:0] AMC_STAMP_CTRL_RST = 8'h00;
  localparam logic [7:0] AMC_READ_UNMAPPED = 8'h00;

  // ==========================================================
  // Timestamp control field positions
  localparam int AMC_STAMP_RECV_EN_BIT = 0;
  localparam int AMC_STAMP_PECL_BIT = 1;

  // ==========================================================
  // Power mode codes
  typedef enum logic [7:0] {
    AMC_PMODE_LOW_POWER = 8'h46,
    AMC_PMODE_HIGH_PERF = 8'h4B
  } amc_pmode_t;
  localparam logic [7:0] AMC_POWER_MODE_RST = 8'h4B;
endpackage

/* common/amc_cap_if.sv */
interface amc_cap_if;
  logic capture_valid;
  logic [23:0] capture_data;
  logic [23:0] position;

  modport capt (
    input capture_valid,
    input capture_data,
    output position
  );
  modport user (
    output capture_valid,
    output capture_data,
    input position
  );
endinterface

/* design/amc_edge_capture.sv */
module amc_edge_capture
  import amc_pkg::*;
(
  input wire logic clock, // System clock
  input wire logic rst, // Synchronous reset
  amc_cap_if.capt cap // Capture strobe, data and held position
);
  logic [23:0] position_ff;
  logic [23:0] nxt_position;

  // Refresh on each capture, hold in between
  assign nxt_position = cap.capture_valid ? cap.capture_data : position_ff;

  always_ff @(posedge clock) begin
    if (rst) begin
      position_ff <= AMC_EDGE_POS_RST;
    end else begin
      position_ff <= nxt_position;
    end
  end

  assign cap.position = position_ff;
endmodule

/* design/amc_misc_regs.sv */
module amc_misc_regs
  import amc_pkg::*;
(
  input wire logic clock, // System clock, 100 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic [7:0] reg_addr, // Register byte address
  input wire logic reg_wr, // Write strobe, one cycle
  input wire logic [7:0] reg_wdata, // Write data byte
  input wire logic reg_rd, // Read strobe, one cycle
  output logic [7:0] reg_rdata, // Read data byte
  output logic reg_rvalid, // Read data valid, one cycle
  input wire logic edge_capture_valid, // New reference edge captured
  input wire logic [23:0] edge_capture_data, // Position of captured edge
  output logic [15:0] full_scale_code, // Full-scale adjustment, all channels
  output logic [7:0] power_mode_code, // Raw power mode code
  output logic low_power_sel, // Low power mode selected
  output logic high_perf_sel, // High performance mode selected
  output logic power_mode_reserved, // Reserved power mode code held
  output logic stamp_input_pecl_mode, // Timestamp input PECL mode
  output logic stamp_input_receiver_enable // Timestamp receiver enable
);
  // ==========================================================
  // Edge position capture
  amc_cap_if cap_bus ();

  assign cap_bus.capture_valid = edge_capture_valid;
  assign cap_bus.capture_data = edge_capture_data;

  amc_edge_capture u_capture (
    .clock(clock),
    .rst(rst),
    .cap(cap_bus.capt)
  );

  // ==========================================================
  // Storage
  logic [15:0] full_scale_ff;
  logic [15:0] nxt_full_scale;
  logic [7:0] power_mode_ff;
  logic [7:0] nxt_power_mode;
  logic [7:0] stamp_ctrl_ff;
  logic [7:0] nxt_stamp_ctrl;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic rvalid_ff;
  logic nxt_rvalid;
  logic low_power_ff;
  logic high_perf_ff;
  logic reserved_ff;
  logic nxt_low_power;
  logic nxt_high_perf;
  logic nxt_reserved;

  // ==========================================================
  // Write decode
  logic wr_fs_b0;
  logic wr_fs_b1;
  logic wr_pmode;
  logic wr_stamp;

  // Read-only position bytes and holes have no select, so writes there are lost
  assign wr_fs_b0 = reg_wr && (reg_addr == AMC_ADDR_FULL_SCALE_B0);
  assign wr_fs_b1 = reg_wr && (reg_addr == AMC_ADDR_FULL_SCALE_B1);
  assign wr_pmode = reg_wr && (reg_addr == AMC_ADDR_POWER_MODE);
  assign wr_stamp = reg_wr && (reg_addr == AMC_ADDR_STAMP_CTRL);

  // Any code is stored; range advice is left to software
  assign nxt_full_scale = {wr_fs_b1 ? reg_wdata : full_scale_ff[15:8],
                           wr_fs_b0 ? reg_wdata : full_scale_ff[7:0]};
  // Reserved codes are stored too and flagged by the decode below
  assign nxt_power_mode = wr_pmode ? reg_wdata : power_mode_ff;
  // Upper bits are stored as written so they read back
  assign nxt_stamp_ctrl = wr_stamp ? reg_wdata : stamp_ctrl_ff;

  // ==========================================================
  // Power mode decode from the stored code
  // Flags lag the code by one cycle so that they leave from flip-flops
  assign nxt_low_power = (power_mode_ff == AMC_PMODE_LOW_POWER);
  assign nxt_high_perf = (power_mode_ff == AMC_PMODE_HIGH_PERF);
  assign nxt_reserved = !(nxt_low_power || nxt_high_perf);

  // ==========================================================
  // Read selection; unmapped addresses read zero
  logic [23:0] position;
  logic [7:0] rd_mux_data;
  logic rd_pos_b0;
  logic rd_pos_b1;
  logic rd_pos_b2;
  logic rd_fs_b0;
  logic rd_fs_b1;
  logic rd_pmode;
  logic rd_stamp;
  logic rd_hole;

  assign position = cap_bus.position;

  assign rd_pos_b0 = (reg_addr == AMC_ADDR_EDGE_POS_B0);
  assign rd_pos_b1 = (reg_addr == AMC_ADDR_EDGE_POS_B1);
  assign rd_pos_b2 = (reg_addr == AMC_ADDR_EDGE_POS_B2);
  assign rd_fs_b0 = (reg_addr == AMC_ADDR_FULL_SCALE_B0);
  assign rd_fs_b1 = (reg_addr == AMC_ADDR_FULL_SCALE_B1);
  assign rd_pmode = (reg_addr == AMC_ADDR_POWER_MODE);
  assign rd_stamp = (reg_addr == AMC_ADDR_STAMP_CTRL);
  assign rd_hole = !(rd_pos_b0 || rd_pos_b1 || rd_pos_b2 || rd_fs_b0 || rd_fs_b1 ||
                     rd_pmode || rd_stamp);

  // Selects are one-hot, so the OR of the masked bytes is the multiplexer.
  // Bytes are read one at a time: a capture between two reads tears the value.
  assign rd_mux_data = ({8{rd_pos_b0}} & position[7:0]) |
                       ({8{rd_pos_b1}} & position[15:8]) |
                       ({8{rd_pos_b2}} & position[23:16]) |
                       ({8{rd_fs_b0}} & full_scale_ff[7:0]) |
                       ({8{rd_fs_b1}} & full_scale_ff[15:8]) |
                       ({8{rd_pmode}} & power_mode_ff) |
                       ({8{rd_stamp}} & stamp_ctrl_ff) |
                       ({8{rd_hole}} & AMC_READ_UNMAPPED);

  // A read and a write in one cycle return the old value
  assign nxt_rdata = reg_rd ? rd_mux_data : rdata_ff;
  assign nxt_rvalid = reg_rd;

  // ==========================================================
  // Register updates
  always_ff @(posedge clock) begin
    if (rst) begin
      full_scale_ff <= AMC_FULL_SCALE_RST;
    end else begin
      full_scale_ff <= nxt_full_scale;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      power_mode_ff <= AMC_POWER_MODE_RST;
    end else begin
      power_mode_ff <= nxt_power_mode;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      stamp_ctrl_ff <= AMC_STAMP_CTRL_RST;
    end else begin
      stamp_ctrl_ff <= nxt_stamp_ctrl;
    end
  end

  // Decoded flags reset to the high performance state
  always_ff @(posedge clock) begin
    if (rst) begin
      low_power_ff <= 1'b0;
    end else begin
      low_power_ff <= nxt_low_power;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      high_perf_ff <= 1'b1;
    end else begin
      high_perf_ff <= nxt_high_perf;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      reserved_ff <= 1'b0;
    end else begin
      reserved_ff <= nxt_reserved;
    end
  end

  // Read data holds until the next read; valid pulses for one cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_ff <= AMC_READ_UNMAPPED;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= nxt_rvalid;
    end
  end

  // ==========================================================
  // Outputs
  assign reg_rdata = rdata_ff;
  assign reg_rvalid = rvalid_ff;
  assign full_scale_code = full_scale_ff;
  assign power_mode_code = power_mode_ff;
  assign low_power_sel = low_power_ff;
  assign high_perf_sel = high_perf_ff;
  assign power_mode_reserved = reserved_ff;
  assign stamp_input_pecl_mode = stamp_ctrl_ff[AMC_STAMP_PECL_BIT];
  assign stamp_input_receiver_enable = stamp_ctrl_ff[AMC_STAMP_RECV_EN_BIT];
endmodule

/* test/amc_misc_regs_properties.sv */
module amc_misc_regs_chk
  import amc_pkg::*;
(
  input wire logic clock, // Clock
  input wire logic rst, // Reset
  input wire logic [7:0] reg_addr, // Address
  input wire logic reg_wr, // Write
  input wire logic [7:0] reg_wdata, // Data
  input wire logic reg_rd, // Read
  input wire logic [7:0] reg_rdata, // Read data
  input wire logic reg_rvalid, // Read valid
  input wire logic edge_capture_valid, // Capture
  input wire logic [23:0] edge_capture_data, // Position
  input wire logic [15:0] full_scale_code, // Range
  input wire logic [7:0] power_mode_code, // Mode
  input wire logic low_power_sel, // Low power
  input wire logic high_perf_sel, // High perf
  input wire logic power_mode_reserved, // Reserved code
  input wire logic stamp_input_pecl_mode, // Pecl
  input wire logic stamp_input_receiver_enable // Receiver
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // ==========================================================
  // Register relations
  property p_rv; 1'b1 |=> reg_rvalid == $past(reg_rd); endproperty
  a_rv: assert property (p_rv) else $error("rvalid mismatch");
  property p_rst; $fell(rst) |-> full_scale_code == 16'hA000 && power_mode_code == 8'h4B; endproperty
  a_rst: assert property (p_rst) else $error("reset value");
  property p_fsl; reg_wr && reg_addr == 8'h30 |=> full_scale_code[7:0] == $past(reg_wdata); endproperty
  a_fsl: assert property (p_fsl) else $error("range low byte");
  property p_fsh; reg_wr && reg_addr == 8'h31 |=> full_scale_code[15:8] == $past(reg_wdata); endproperty
  a_fsh: assert property (p_fsh) else $error("range high byte");
  property p_low; power_mode_code == 8'h46 |=> low_power_sel && !high_perf_sel; endproperty
  a_low: assert property (p_low) else $error("low power flag");
  property p_high; power_mode_code == 8'h4B |=> high_perf_sel && !power_mode_reserved; endproperty
  a_high: assert property (p_high) else $error("high perf flag");
  property p_res; power_mode_code != 8'h46 && power_mode_code != 8'h4B |=> power_mode_reserved &&
    !low_power_sel && !high_perf_sel; endproperty
  a_res: assert property (p_res) else $error("reserved flag");
  property p_st; reg_wr && reg_addr == 8'h3B |=> {stamp_input_pecl_mode,
    stamp_input_receiver_enable} == $past(reg_wdata[1:0]); endproperty
  a_st: assert property (p_st) else $error("stamp bits");
  property p_cap; edge_capture_valid ##1 (reg_rd && reg_addr == 8'h2C && !edge_capture_valid)
    |=> reg_rdata == $past(edge_capture_data[7:0], 2); endproperty
  a_cap: assert property (p_cap) else $error("edge position");
endmodule
bind amc_misc_regs amc_misc_regs_chk i_chk (
  .clock(clock),
  .rst(rst),
  .reg_addr(reg_addr),
  .reg_wr(reg_wr),
  .reg_wdata(reg_wdata),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid),
  .edge_capture_valid(edge_capture_valid),
  .edge_capture_data(edge_capture_data),
  .full_scale_code(full_scale_code),
  .power_mode_code(power_mode_code),
  .low_power_sel(low_power_sel),
  .high_perf_sel(high_perf_sel),
  .power_mode_reserved(power_mode_reserved),
  .stamp_input_pecl_mode(stamp_input_pecl_mode),
  .stamp_input_receiver_enable(stamp_input_receiver_enable)
);

/* test/tb.sv */
module tb
  import amc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, edge_capture_valid = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, power_mode_code;
  logic [23:0] edge_capture_data = 24'h000000;
  logic [15:0] full_scale_code;
  logic reg_rvalid, low_power_sel, high_perf_sel, power_mode_reserved;
  logic stamp_input_pecl_mode, stamp_input_receiver_enable;
  int fail_count = 0;
  int cmp_count = 0;
  amc_misc_regs i_dut (
    .clock(clock),
    .rst(rst),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_wdata(reg_wdata),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid),
    .edge_capture_valid(edge_capture_valid),
    .edge_capture_data(edge_capture_data),
    .full_scale_code(full_scale_code),
    .power_mode_code(power_mode_code),
    .low_power_sel(low_power_sel),
    .high_perf_sel(high_perf_sel),
    .power_mode_reserved(power_mode_reserved),
    .stamp_input_pecl_mode(stamp_input_pecl_mode),
    .stamp_input_receiver_enable(stamp_input_receiver_enable)
  );
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic chk(logic [23:0] got, logic [23:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] v);
    @(posedge clock) #1;
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(posedge clock) #1;
    reg_wr = 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge clock) #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clock) #1;
    reg_rd = 1'b0;
    chk(reg_rvalid, 1'b1);
    chk(reg_rdata, e);
  endtask
  task automatic print_verdict;
    $display("cmp_count=%0d fail_count=%0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_fs;
    chk(full_scale_code, AMC_FULL_SCALE_RST);
    rd(8'h31, 8'hA0);
    rd(8'h2E, 8'h00);
    wr(8'h30, 8'h00);
    wr(8'h31, 8'h20);
    chk(full_scale_code, 16'h2000);
    wr(8'h31, 8'hFF);
    wr(8'h30, 8'hFF);
    rd(8'h30, 8'hFF);
    chk(full_scale_code, 16'hFFFF);
    wr(8'h2C, 8'h55);
    rd(8'h2C, 8'h00);
    rd(8'h33, AMC_READ_UNMAPPED);
    $display("t_fs done");
  endtask
  task automatic t_pm;
    logic [7:0] c [3] = '{8'h46, 8'h55, 8'h4B};
    logic [2:0] e [3] = '{3'h4, 3'h1, 3'h2};
    chk({low_power_sel, high_perf_sel, power_mode_reserved}, 3'h2);
    for (int i = 0; i < 3; i++) begin
      wr(8'h37, c[i]);
      chk(power_mode_code, c[i]);
      @(posedge clock) #1;
      chk({low_power_sel, high_perf_sel, power_mode_reserved}, e[i]);
      rd(8'h37, c[i]);
    end
    $display("t_pm done");
  endtask
  task automatic t_st;
    chk({stamp_input_pecl_mode, stamp_input_receiver_enable}, 2'h0);
    for (logic [7:0] i = 8'h00; i < 8'h04; i++) begin
      wr(8'h3B, i);
      chk({stamp_input_pecl_mode, stamp_input_receiver_enable}, i[1:0]);
      rd(8'h3B, i);
    end
    $display("t_st done");
  endtask
  task automatic t_cap;
    logic [23:0] v [2] = '{24'hABCDEF, 24'h5A0F31};
    foreach (v[i]) begin
      @(posedge clock) #1;
      edge_capture_data = v[i];
      edge_capture_valid = 1'b1;
      @(posedge clock) #1;
      edge_capture_valid = 1'b0;
      edge_capture_data = ~v[i];
      reg_addr = 8'h2C;
      reg_rd = 1'b1;
      @(posedge clock) #1;
      reg_rd = 1'b0;
      chk(reg_rdata, v[i][7:0]);
      rd(8'h2D, v[i][15:8]);
      rd(8'h2E, v[i][23:16]);
    end
    $display("t_cap done");
  endtask
  task automatic t_rst;
    wr(8'h30, 8'h5A);
    wr(8'h37, 8'h46);
    wr(8'h3B, 8'h03);
    @(posedge clock) #1;
    rst = 1'b1;
    repeat (2) @(posedge clock);
    #1 rst = 1'b0;
    chk(full_scale_code, AMC_FULL_SCALE_RST);
    chk(power_mode_code, AMC_POWER_MODE_RST);
    chk({low_power_sel, high_perf_sel, power_mode_reserved}, 3'h2);
    chk({stamp_input_pecl_mode, stamp_input_receiver_enable}, 2'h0);
    chk(reg_rvalid, 1'b0);
    chk(reg_rdata, 8'h00);
    rd(8'h2C, 8'h00);
    rd(8'h2E, 8'h00);
    $display("t_rst done");
  endtask
  initial begin
    repeat (4) @(posedge clock);
    #1 rst = 1'b0;
    t_fs;
    t_pm;
    t_st;
    t_cap;
    t_rst;
    print_verdict;
  end
  initial begin
    #20000;
    fail_count++;
    print_verdict;
  end
endmodule
